//--- dpb_axis_model.sv
// dpb_axis_model: behavioural axis with external and motor encoders
// assumes the bench steers target position, encoder skew and brake slip
`timescale 1ns/100ps
module dpb_axis_model (
	input  wire logic                      ref_clk,
	input  wire logic                      rst_n,
	input  wire logic [dpb_pkg::POS_W-1:0] target_pos,
	input  wire logic [dpb_pkg::POS_W-1:0] enc_skew,
	input  wire logic                      slip_en,
	input  wire logic                      test_torque_req,
	output logic      [dpb_pkg::POS_W-1:0] ext_abs_pos,
	output logic      [dpb_pkg::POS_W-1:0] motor_abs_pos,
	output logic      [dpb_pkg::SPD_W-1:0] speed_abs
);
	logic [dpb_pkg::POS_W-1:0] pos_reg;
	logic                      moving;
	// the brake gives way only when the bench asks and test torque is applied
	assign moving = slip_en && test_torque_req;
	always_ff @(negedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			pos_reg <= 32'h0;
		else if (moving)
			pos_reg <= pos_reg + 32'h10;
		else if (!slip_en)
			pos_reg <= target_pos;
	end
	assign ext_abs_pos = pos_reg;
	assign motor_abs_pos = pos_reg + enc_skew;
	assign speed_abs = moving ? 16'h10 : 16'h0;
endmodule // dpb_axis_model

//--- dpb_monitor.sv
// dpb_monitor: position-limit monitor, safe brake output stage and brake-test sequencer
// assumes inputs synchronous to ref_clk and encoder positions already in one unit
`timescale 1ns/100ps
module dpb_monitor #(parameter int unsigned TICK_CYC = dpb_pkg::TICK_CYC) (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	input  wire logic                        position_limit_activate_in,
	input  wire logic                        brake_test_activate_in,
	input  wire logic [dpb_pkg::POS_W-1:0]   ext_abs_pos,
	input  wire logic [dpb_pkg::POS_W-1:0]   motor_abs_pos,
	input  wire logic [dpb_pkg::SPD_W-1:0]   speed_abs,
	input  wire logic                        torque_removal,
	input  wire logic                        drive_enable,
	input  wire logic                        motor_on,
	input  wire logic                        brake_link_config_cmd,
	input  wire dpb_pkg::dpb_lim_cfg_t       lim_cfg,
	input  wire dpb_pkg::dpb_bt_cfg_t        bt_cfg,
	output logic                             safe_range_ack_out,
	output logic                             emergency_ramp_stop,
	output logic                             brake_output_pos,
	output logic                             brake_output_neg,
	output logic                             safe_standstill_ack_out,
	output logic                             brake_test_success_out,
	output logic                             test_torque_req,
	output logic [dpb_pkg::TORQ_W-1:0]       test_torque,
	output logic                             test_second_brake,
	output logic                             brake_test_due,
	output logic                             brake_test_overdue,
	output logic                             period_cfg_error
);

	////////////////////////////////////////////////////////////////////////////
	// common millisecond tick and edge detection

	localparam int unsigned TICK_W = $clog2(TICK_CYC);
	logic [TICK_W-1:0] tick_cnt_reg;
	logic              tick;
	logic              lim_act_d_reg;
	logic              bt_act_d_reg;
	logic              lim_fall;
	logic              bt_fall;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
		end else if (tick) begin
			tick_cnt_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
		end
	end
	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYC - 1));

	// idle level of the activation inputs is high, so reset to high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lim_act_d_reg <= 1'b1;
			bt_act_d_reg  <= 1'b1;
		end else begin
			lim_act_d_reg <= position_limit_activate_in;
			bt_act_d_reg  <= brake_test_activate_in;
		end
	end
	assign lim_fall = lim_act_d_reg & ~position_limit_activate_in;
	assign bt_fall  = bt_act_d_reg & ~brake_test_activate_in;

	function automatic logic [dpb_pkg::POS_W-1:0] abs_diff(
		input logic [dpb_pkg::POS_W-1:0] a,
		input logic [dpb_pkg::POS_W-1:0] b
	);
		abs_diff = ($signed(a) > $signed(b)) ? a - b : b - a;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// position-limit monitor

	logic                      lim_arm_reg;
	logic                      lim_act_reg;
	logic [dpb_pkg::TMR_W-1:0] lim_tmr_reg;
	logic                      lim_active;
	logic                      enc_mismatch;
	logic                      lim_viol;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			lim_arm_reg <= 1'b0;
			lim_act_reg <= 1'b0;
			lim_tmr_reg <= dpb_pkg::TMR_RST;
		end else if (position_limit_activate_in && !lim_cfg.permanent) begin
			lim_arm_reg <= 1'b0;
			lim_act_reg <= 1'b0;
		end else if (lim_fall) begin
			lim_arm_reg <= 1'b1;
			lim_tmr_reg <= lim_cfg.delay_ms;
		end else if (lim_arm_reg && tick) begin
			if (lim_tmr_reg == '0) begin
				lim_arm_reg <= 1'b0;
				lim_act_reg <= 1'b1;
			end else begin
				lim_tmr_reg <= lim_tmr_reg - 1'b1;
			end
		end
	end

	assign lim_active = lim_act_reg | lim_cfg.permanent;
	assign enc_mismatch = abs_diff(ext_abs_pos, motor_abs_pos) > lim_cfg.enc_tol;
	assign lim_viol = lim_active & (($signed(ext_abs_pos) > $signed(lim_cfg.pos_max))
		| ($signed(ext_abs_pos) < $signed(lim_cfg.pos_min))
		| (speed_abs > lim_cfg.spd_max) | enc_mismatch);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			safe_range_ack_out <= 1'b0;
		end else begin
			safe_range_ack_out <= lim_active & ~lim_viol;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// brake-test sequencer

	dpb_pkg::dpb_bt_state_t    bt_state_reg;
	logic [dpb_pkg::TMR_W-1:0] bt_tmr_reg;
	logic                      bt_second_reg;
	logic [dpb_pkg::POS_W-1:0] still_pos_reg;
	logic                      bt_moved;
	logic                      bt_fail_evt;
	logic                      bt_done_evt;
	logic                      bt_expired;

	assign bt_expired  = tick && (bt_tmr_reg == '0);
	assign bt_moved    = abs_diff(motor_abs_pos, still_pos_reg) > bt_cfg.still_tol;
	assign bt_fail_evt = (bt_state_reg == dpb_pkg::DPB_BT_MON) && bt_moved;
	assign bt_done_evt = (bt_state_reg == dpb_pkg::DPB_BT_VENT) && bt_expired
		&& (bt_second_reg || !bt_cfg.two_brakes);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bt_state_reg  <= dpb_pkg::DPB_BT_IDLE;
			bt_tmr_reg    <= dpb_pkg::TMR_RST;
			bt_second_reg <= 1'b0;
			still_pos_reg <= '0;
		end else if (emergency_ramp_stop && bt_state_reg != dpb_pkg::DPB_BT_FAIL) begin
			bt_state_reg <= dpb_pkg::DPB_BT_IDLE;
		end else begin
			unique case (bt_state_reg)
				dpb_pkg::DPB_BT_IDLE: begin
					if (bt_fall) begin
						bt_state_reg  <= dpb_pkg::DPB_BT_DELAY;
						bt_tmr_reg    <= bt_cfg.delay_ms;
						bt_second_reg <= 1'b0;
					end
				end
				dpb_pkg::DPB_BT_DELAY, dpb_pkg::DPB_BT_ENG, dpb_pkg::DPB_BT_VENT: begin
					if (bt_expired) begin
						if (bt_state_reg == dpb_pkg::DPB_BT_DELAY) begin
							bt_state_reg <= dpb_pkg::DPB_BT_ENG;
							bt_tmr_reg   <= bt_cfg.engage_ms;
						end else if (bt_state_reg == dpb_pkg::DPB_BT_ENG) begin
							bt_state_reg  <= dpb_pkg::DPB_BT_MON;
							bt_tmr_reg    <= bt_cfg.monitor_ms;
							still_pos_reg <= motor_abs_pos;
						end else if (bt_cfg.two_brakes && !bt_second_reg) begin
							bt_state_reg  <= dpb_pkg::DPB_BT_ENG;
							bt_tmr_reg    <= bt_cfg.engage_ms;
							bt_second_reg <= 1'b1;
						end else begin
							bt_state_reg <= dpb_pkg::DPB_BT_IDLE;
						end
					end else if (tick) begin
						bt_tmr_reg <= bt_tmr_reg - 1'b1;
					end
				end
				dpb_pkg::DPB_BT_MON: begin
					if (bt_moved) begin
						bt_state_reg <= dpb_pkg::DPB_BT_FAIL;
					end else if (bt_expired) begin
						bt_state_reg <= dpb_pkg::DPB_BT_VENT;
						bt_tmr_reg   <= bt_cfg.engage_ms;
					end else if (tick) begin
						bt_tmr_reg <= bt_tmr_reg - 1'b1;
					end
				end
				dpb_pkg::DPB_BT_FAIL: begin
					if (bt_fall) begin
						bt_state_reg  <= dpb_pkg::DPB_BT_DELAY;
						bt_tmr_reg    <= bt_cfg.delay_ms;
						bt_second_reg <= 1'b0;
					end
				end
				default: bt_state_reg <= dpb_pkg::DPB_BT_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			test_torque_req         <= 1'b0;
			test_torque             <= '0;
			safe_standstill_ack_out <= 1'b0;
			test_second_brake       <= 1'b0;
		end else begin
			test_torque_req   <= (bt_state_reg == dpb_pkg::DPB_BT_MON);
			test_torque       <= dpb_pkg::TORQ_W'((32'(bt_cfg.max_load) * dpb_pkg::TORQ_NUM)
				/ dpb_pkg::TORQ_DEN);
			test_second_brake <= bt_second_reg;
			safe_standstill_ack_out <= (bt_state_reg == dpb_pkg::DPB_BT_MON) && !bt_moved;
		end
	end

	// success flag held until next test starts
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			brake_test_success_out <= 1'b0;
		end else if (bt_done_evt) begin
			brake_test_success_out <= 1'b1;
		end else if (bt_fall || bt_fail_evt) begin
			brake_test_success_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// cyclic test period supervision

	logic [dpb_pkg::TMR_W-1:0] per_tmr_reg;
	logic [dpb_pkg::TMR_W-1:0] tol_tmr_reg;
	logic                      due_reg;
	logic                      cfg_bad;

	assign cfg_bad = bt_cfg.period_ms > dpb_pkg::TMR_W'(dpb_pkg::TEST_MAX_MS);

	// after reset the test is due
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			due_reg     <= 1'b1;
			per_tmr_reg <= dpb_pkg::TMR_RST;
			tol_tmr_reg <= dpb_pkg::TMR_RST;
			brake_test_overdue <= 1'b0;
		end else if (bt_done_evt) begin
			due_reg     <= 1'b0;
			per_tmr_reg <= bt_cfg.period_ms;
			tol_tmr_reg <= dpb_pkg::TMR_RST;
			brake_test_overdue <= 1'b0;
		end else if (tick) begin
			if (!due_reg) begin
				if (per_tmr_reg == '0) begin
					due_reg     <= 1'b1;
					tol_tmr_reg <= dpb_pkg::TMR_RST;
				end else begin
					per_tmr_reg <= per_tmr_reg - 1'b1;
				end
			// counts up from a constant, so the tolerance applies right after reset
			end else if (tol_tmr_reg >= bt_cfg.tol_ms) begin
				brake_test_overdue <= 1'b1;
			end else begin
				tol_tmr_reg <= tol_tmr_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			brake_test_due   <= 1'b1;
			period_cfg_error <= 1'b0;
		end else begin
			brake_test_due   <= due_reg;
			period_cfg_error <= cfg_bad;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// emergency stop and brake output stage

	// violation latches ramp stop; failed test too
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			emergency_ramp_stop <= 1'b0;
		end else if (lim_viol || bt_fail_evt || brake_test_overdue || cfg_bad) begin
			emergency_ramp_stop <= 1'b1;
		end
	end

	logic brake_vent;
	// torque removal and fault stop dominate
	// test engages via positive pole only
	assign brake_vent = !torque_removal && !emergency_ramp_stop
		&& (!brake_link_config_cmd || (drive_enable && motor_on));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			brake_output_pos <= 1'b0;
			brake_output_neg <= 1'b0;
		end else begin
			brake_output_pos <= brake_vent && (bt_state_reg != dpb_pkg::DPB_BT_ENG)
				&& (bt_state_reg != dpb_pkg::DPB_BT_MON);
			brake_output_neg <= brake_vent;
		end
	end

endmodule // dpb_monitor

//--- dpb_monitor_properties.sv
// dpb_monitor_properties: port-level checks on the position, brake and brake-test monitor
// assumes one ref_clk domain and async active-low rst_n; bound at the file foot
`timescale 1ns/100ps
module dpb_monitor_properties (
	input wire logic                        ref_clk,
	input wire logic                        rst_n,
	input wire logic                        position_limit_activate_in,
	input wire logic [dpb_pkg::POS_W-1:0]   ext_abs_pos,
	input wire logic                        torque_removal,
	input wire logic                        drive_enable,
	input wire logic                        motor_on,
	input wire logic                        brake_link_config_cmd,
	input wire dpb_pkg::dpb_lim_cfg_t       lim_cfg,
	input wire dpb_pkg::dpb_bt_cfg_t        bt_cfg,
	input wire logic                        safe_range_ack_out,
	input wire logic                        emergency_ramp_stop,
	input wire logic                        brake_output_pos,
	input wire logic                        brake_output_neg,
	input wire logic                        safe_standstill_ack_out,
	input wire logic                        brake_test_success_out,
	input wire logic                        test_torque_req,
	input wire logic [dpb_pkg::TORQ_W-1:0]  test_torque,
	input wire logic                        brake_test_due,
	input wire logic                        period_cfg_error
);
	localparam int unsigned MAX_MS = dpb_pkg::TEST_MAX_MS;
	logic [31:0] torq_full;
	assign torq_full = 32'(bt_cfg.max_load) * dpb_pkg::TORQ_NUM / dpb_pkg::TORQ_DEN;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	sequence s_off_range;
		$signed(ext_abs_pos) > $signed(lim_cfg.pos_max)
			|| $signed(ext_abs_pos) < $signed(lim_cfg.pos_min);
	endsequence
	sequence s_link_engage;
		brake_link_config_cmd && !(drive_enable && motor_on);
	endsequence
	brake_engage_a: assert property (
		torque_removal [*3] |-> !brake_output_pos && !brake_output_neg)
		else $error("brake vented under torque removal");
	brake_poles_a: assert property (!(brake_output_pos && !brake_output_neg))
		else $error("brake poles split");
	link_follow_a: assert property (s_link_engage [*3] |-> !brake_output_pos)
		else $error("linked brake not engaged");
	stop_override_a: assert property (
		emergency_ramp_stop [*3] |-> !brake_output_pos && !brake_output_neg)
		else $error("brake vented during stop");
	limit_cancel_a: assert property (
		(position_limit_activate_in && !lim_cfg.permanent) [*3] |-> !safe_range_ack_out)
		else $error("range ack without activation");
	range_stop_a: assert property (
		safe_range_ack_out ##1 s_off_range [*2] |-> ##[0:3] emergency_ramp_stop)
		else $error("no stop on range violation");
	test_torque_a: assert property (
		test_torque_req |-> !brake_output_pos && test_torque == torq_full[15:0])
		else $error("test torque wrong");
	standstill_ack_a: assert property (
		safe_standstill_ack_out |-> test_torque_req && !brake_output_pos)
		else $error("standstill ack outside window");
	success_vent_a: assert property (
		$rose(brake_test_success_out) |-> brake_output_pos && brake_output_neg)
		else $error("success while engaged");
	due_clear_a: assert property (
		$rose(brake_test_success_out) |-> ##[1:2] !brake_test_due)
		else $error("test still due");
	period_limit_a: assert property (
		$stable(bt_cfg.period_ms) [*3] |-> period_cfg_error == (bt_cfg.period_ms > MAX_MS))
		else $error("period check wrong");
	due_reset_a: assert property ($rose(rst_n) |-> brake_test_due)
		else $error("test not due after reset");
endmodule // dpb_monitor_properties

bind dpb_monitor dpb_monitor_properties u_props (
	.ref_clk, .rst_n, .position_limit_activate_in, .ext_abs_pos, .torque_removal,
	.drive_enable, .motor_on, .brake_link_config_cmd, .lim_cfg, .bt_cfg, .safe_range_ack_out,
	.emergency_ramp_stop, .brake_output_pos, .brake_output_neg, .safe_standstill_ack_out,
	.brake_test_success_out, .test_torque_req, .test_torque, .brake_test_due, .period_cfg_error
);

//--- dpb_pkg.sv
// dpb_pkg: shared constants and types for the position, brake and brake-test monitor
// assumes a single 50 MHz clock; all long times are millisecond fields of lim_cfg and bt_cfg
package dpb_pkg;

	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned POS_W         = 32;
	localparam int unsigned SPD_W         = 16;
	localparam int unsigned TORQ_W        = 16;

	// test torque factor 1.3 as 13/10
	localparam int unsigned TORQ_NUM      = 13;
	localparam int unsigned TORQ_DEN      = 10;

	// one-millisecond tick drives all configurable timers
	localparam int unsigned TICK_MS       = 1;
	localparam int unsigned TICK_CYC      = CLK_HZ / 1000 * TICK_MS;

	// longest accepted brake-test period: 8 hours in milliseconds
	localparam int unsigned TEST_MAX_H    = 8;
	localparam int unsigned TEST_MAX_MS   = TEST_MAX_H * 3600 * 1000;
	localparam int unsigned TMR_W         = 32;

	localparam logic [TMR_W-1:0] TMR_RST  = 32'h0000_0000;

	typedef enum logic [2:0] {
		DPB_BT_IDLE  = 3'b000,
		DPB_BT_DELAY = 3'b001,
		DPB_BT_ENG   = 3'b011,
		DPB_BT_MON   = 3'b010,
		DPB_BT_VENT  = 3'b110,
		DPB_BT_FAIL  = 3'b111
	} dpb_bt_state_t;

	typedef struct packed {
		logic [POS_W-1:0] pos_max;
		logic [POS_W-1:0] pos_min;
		logic [SPD_W-1:0] spd_max;
		logic [POS_W-1:0] enc_tol;
		logic [TMR_W-1:0] delay_ms;
		logic             permanent;
	} dpb_lim_cfg_t;

	typedef struct packed {
		logic [TMR_W-1:0]  delay_ms;
		logic [TMR_W-1:0]  engage_ms;
		logic [TMR_W-1:0]  monitor_ms;
		logic [TMR_W-1:0]  period_ms;
		logic [TMR_W-1:0]  tol_ms;
		logic [POS_W-1:0]  still_tol;
		logic [TORQ_W-1:0] max_load;
		logic              two_brakes;
	} dpb_bt_cfg_t;

endpackage

//--- tb_top.sv
// tb_top: self-checking bench for the position, brake and brake-test monitor
// assumes dpb_axis_model as far side; timer configs of 0 ms keep phases to one tick
// the millisecond tick is shortened to 20 cycles so every phase fits the run budget
`timescale 1ns/100ps
module tb_top;
	logic                       ref_clk, rst_n, torque_removal, drive_enable, motor_on;
	logic                       position_limit_activate_in, brake_test_activate_in;
	logic                       brake_link_config_cmd, slip_en;
	logic [dpb_pkg::POS_W-1:0]  ext_abs_pos, motor_abs_pos, target_pos, enc_skew;
	logic [dpb_pkg::SPD_W-1:0]  speed_abs;
	logic [dpb_pkg::TORQ_W-1:0] test_torque;
	dpb_pkg::dpb_lim_cfg_t      lim_cfg;
	dpb_pkg::dpb_bt_cfg_t       bt_cfg;
	logic                       safe_range_ack_out, emergency_ramp_stop, brake_output_pos;
	logic                       brake_output_neg, safe_standstill_ack_out, test_torque_req;
	logic                       brake_test_success_out, test_second_brake, brake_test_due;
	logic                       brake_test_overdue, period_cfg_error;
	logic [31:0]                bits;
	int                         miscompares, checked;
	wire logic [5:0]            mon = {brake_test_success_out, test_second_brake,
		test_torque_req, brake_output_pos, safe_range_ack_out, emergency_ramp_stop};
	dpb_monitor #(.TICK_CYC(20)) i_dut (
		.ref_clk, .rst_n, .position_limit_activate_in, .brake_test_activate_in,
		.ext_abs_pos, .motor_abs_pos, .speed_abs, .torque_removal, .drive_enable,
		.motor_on, .brake_link_config_cmd, .lim_cfg, .bt_cfg, .safe_range_ack_out,
		.emergency_ramp_stop, .brake_output_pos, .brake_output_neg, .safe_standstill_ack_out,
		.brake_test_success_out, .test_torque_req, .test_torque, .test_second_brake,
		.brake_test_due, .brake_test_overdue, .period_cfg_error
	);
	dpb_axis_model i_axis (
		.ref_clk, .rst_n, .target_pos, .enc_skew, .slip_en, .test_torque_req,
		.ext_abs_pos, .motor_abs_pos, .speed_abs
	);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic finish_test;
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait: far beyond the longest phase at the shortened tick
	task automatic wait_bit(input int idx, input logic val);
		int n;
		n = 0;
		while (mon[idx] !== val && n < 4000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 4000) begin
			miscompares++;
			finish_test();
		end
	endtask
	function automatic logic [15:0] torque_exp(input logic [15:0] load);
		logic [31:0] p;
		p = 32'(load) * dpb_pkg::TORQ_NUM / dpb_pkg::TORQ_DEN;
		return p[15:0];
	endfunction
	task automatic do_reset;
		rst_n = 1'b0;
		{position_limit_activate_in, brake_test_activate_in, drive_enable, motor_on} = 4'hf;
		{torque_removal, brake_link_config_cmd, slip_en} = 3'h0;
		target_pos = 32'h100;
		enc_skew = 32'h0;
		lim_cfg = '{32'h1000, 32'hffff_f000, 16'h100, 32'h10, 32'h0, 1'b0};
		bt_cfg = '{32'h0, 32'h0, 32'h0, 32'h1_0000, 32'h3e8, 32'h8, 16'h0, 1'b1};
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		bits = $urandom(22003);
		do_reset();
		check(brake_test_due, 1'b1);
		check(brake_test_overdue, 1'b0);
		for (int i = 0; i < 24; i++) begin
			bits = (i < 2) ? 32'(i * 8 + 6) : $urandom;
			{brake_link_config_cmd, motor_on, drive_enable, torque_removal} = bits[3:0];
			repeat (4) @(negedge ref_clk);
			check(brake_output_pos, !bits[0] && (!bits[3] || (bits[1] && bits[2])));
			check(brake_output_neg, !bits[0] && (!bits[3] || (bits[1] && bits[2])));
		end
		do_reset();
		target_pos = $urandom % 32'h1000;
		position_limit_activate_in = 1'b0;
		wait_bit(1, 1'b1);
		check(emergency_ramp_stop, 1'b0);
		position_limit_activate_in = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(safe_range_ack_out, 1'b0);
		position_limit_activate_in = 1'b0;
		wait_bit(1, 1'b1);
		target_pos = 32'h2000;
		wait_bit(0, 1'b1);
		repeat (2) @(negedge ref_clk);
		check(safe_range_ack_out, 1'b0);
		brake_link_config_cmd = 1'b1;
		repeat (4) @(negedge ref_clk);
		check({brake_output_pos, brake_output_neg}, 2'b00);
		do_reset();
		bt_cfg.max_load = 16'($urandom);
		brake_test_activate_in = 1'b0;
		wait_bit(2, 1'b0);
		check(brake_output_neg, 1'b1);
		wait_bit(3, 1'b1);
		check(test_torque, torque_exp(bt_cfg.max_load));
		check({safe_standstill_ack_out, test_second_brake}, 2'b10);
		wait_bit(4, 1'b1);
		wait_bit(3, 1'b1);
		check(safe_standstill_ack_out, 1'b1);
		wait_bit(5, 1'b1);
		check({brake_output_pos, brake_output_neg}, 2'b11);
		repeat (2) @(negedge ref_clk);
		check(brake_test_due, 1'b0);
		brake_test_activate_in = 1'b1;
		bt_cfg.two_brakes = 1'b0;
		@(negedge ref_clk);
		brake_test_activate_in = 1'b0;
		slip_en = 1'b1;
		wait_bit(0, 1'b1);
		check(brake_test_success_out, 1'b0);
		for (int k = 0; k < 2; k++) begin
			do_reset();
			lim_cfg.permanent = 1'b1;
			position_limit_activate_in = 1'b0;
			wait_bit(1, 1'b1);
			if (k == 0)
				enc_skew = 32'h100;
			else
				target_pos = 32'hffff_e000;
			wait_bit(0, 1'b1);
			check(emergency_ramp_stop, 1'b1);
		end
		do_reset();
		bt_cfg.tol_ms = 32'h2;
		wait_bit(0, 1'b1);
		check(brake_test_overdue, 1'b1);
		do_reset();
		for (int k = 0; k < 2; k++) begin
			bt_cfg.period_ms = dpb_pkg::TEST_MAX_MS + k;
			repeat (3) @(negedge ref_clk);
			check(period_cfg_error, k[0]);
		end
		wait_bit(0, 1'b1);
		finish_test();
	end
endmodule // tb_top
